// [bench/pwm_load.sv]
`timescale 1ns/10ps
`default_nettype none
module pwm_load (
  // Clock and pin
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        pin_i,
  input  wire logic        oe_i,
  // Measured waveform
  output logic [15:0]      high_o,
  output logic [15:0]      period_o,
  output logic [7:0]       rises_o
);
  // ****
  // Edge timing
  // ****
  logic        lvl;
  logic        prev;
  logic [15:0] cnt;
  // Pull-down at the load: an undriven pin reads low
  assign lvl = oe_i && pin_i;
  always_ff @(posedge clk_i) begin
    prev <= lvl;
    cnt  <= (lvl && !prev) ? 16'h1 : cnt + 16'h1;
    if (lvl && !prev) begin
      period_o <= cnt;
      rises_o  <= rises_o + 8'h1;
    end
    if (!lvl && prev) begin
      high_o <= cnt;
    end
    if (rst_i) begin
      rises_o <= 8'h0;
    end
  end
endmodule
`default_nettype wire

// [bench/pwm_properties.sv]
`timescale 1ns/10ps
`default_nettype none
module pwm_properties
  import pwm_pkg::*;
(
  // Bus and pin
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic [2:0]  hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  input wire logic        pwm_o,
  input wire logic        pwm_oe_o,
  input wire logic        irq_o
);
  // ****
  // Write tracking
  // ****
  logic       req;
  logic       wp;
  logic [7:0] wa;
  logic       mode;
  assign req = hsel_i && htrans_i[1] && hready_i;
  always_ff @(posedge clk_i) begin
    wp <= !rst_i && req && hwrite_i;
    wa <= haddr_i[7:0];
  end
  // Mirror of the mode field, so the pin is judged from the bus alone
  always_ff @(posedge clk_i) begin
    if (rst_i || (wp && wa == ctrl_off)) begin
      mode <= !rst_i && hwdata_i[3:2] == mode_pwm_hi;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ok; hreadyout_o && !hresp_o; endproperty
  a_ok: assert property (p_ok) else $error("bus answer not okay");
  property p_upper; hrdata_o[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("read upper bits set");
  property p_keep; !(req && !hwrite_i) |=> $stable(hrdata_o); endproperty
  a_keep: assert property (p_keep) else $error("read data moved");
  property p_unmap;
    req && !hwrite_i && haddr_i[7:0] > pin_dir_off |=> hrdata_o == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not 0");
  property p_zero;
    wp && wa == ctrl_off && hwdata_i[7:0] == ctrl_rst |-> ##2 (!pwm_o)[*4];
  endproperty
  a_zero: assert property (p_zero) else $error("pin high after clear");
  property p_mode; !mode ##1 !mode |-> !pwm_o; endproperty
  a_mode: assert property (p_mode) else $error("pin high out of mode");
  property p_dir;
    wp && wa == pin_dir_off |-> ##2 pwm_oe_o != $past(hwdata_i[0], 2);
  endproperty
  a_dir: assert property (p_dir) else $error("enable not direction");
  property p_mask;
    wp && wa == enables_off && hwdata_i[7:0] == byte_rst |-> ##2 !irq_o;
  endproperty
  a_mask: assert property (p_mask) else $error("masked irq high");
  c_zero: cover property (wp && wa == ctrl_off && hwdata_i == 32'h0);
  c_irq: cover property ($rose(irq_o));
  c_unmap: cover property (req && haddr_i[7:0] > pin_dir_off);
endmodule
bind ten_bit_pwm_channel pwm_properties chk (.clk_i(clk_i), .rst_i(rst_i),
  .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
  .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
  .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o), .pwm_o(pwm_o), .pwm_oe_o(pwm_oe_o), .irq_o(irq_o));
`default_nettype wire

// [bench/test_ten_bit_pwm_channel.sv]
`timescale 1ns/10ps
`default_nettype none
module test_ten_bit_pwm_channel;
  import pwm_pkg::*;
  logic        clk_i = 1'h0;
  logic        rst_i = 1'h1;
  logic        hsel  = 1'h0;
  logic        hwr   = 1'h0;
  logic [1:0]  htr   = 2'h0;
  logic [31:0] hadr  = 32'h0;
  logic [31:0] hwd   = 32'h0;
  logic [31:0] hrd;
  logic [31:0] q;
  logic        rdy;
  logic        pwm;
  logic        oe;
  logic        irq;
  logic [15:0] hi;
  logic [15:0] per;
  logic [7:0]  rises;
  int          n_errors  = 0;
  int          tests_run = 0;
  ten_bit_pwm_channel uut (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel),
    .haddr_i(hadr), .htrans_i(htr), .hwrite_i(hwr), .hsize_i(3'h2),
    .hwdata_i(hwd), .hready_i(rdy), .hrdata_o(hrd), .hreadyout_o(rdy),
    .hresp_o(), .pwm_o(pwm), .pwm_oe_o(oe), .irq_o(irq));
  pwm_load load (.clk_i(clk_i), .rst_i(rst_i), .pin_i(pwm), .oe_i(oe),
    .high_o(hi), .period_o(per), .rises_o(rises));
  always #20 clk_i = ~clk_i;
  // ****
  // Checking and bus tasks
  // ****
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      n_errors++;
    end
  endtask
  task report_and_stop;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task fail;
    n_errors++;
    report_and_stop;
  endtask
  task step;
    int i;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (rdy !== 1'h1 && i < 64);
    if (rdy !== 1'h1) fail;
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel <= 1'h1;
    htr  <= 2'h2;
    hwr  <= w;
    hadr <= {24'h0, a};
    step;
    htr <= 2'h0;
    hwd <= {24'h0, d};
    step;
    q = hrd;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'h0, a, 8'h0);
    chk("read data", {24'h0, e}, q);
  endtask
  // Waits for n pin rises seen by the load
  task wrise(input int n);
    logic [7:0] s;
    int i;
    @(negedge clk_i);
    s = rises;
    for (i = 0; 8'(rises - s) < n && i < 5000; i++) @(negedge clk_i);
    if (i >= 5000) fail;
    @(posedge clk_i);
  endtask
  task hold(input logic v);
    logic [31:0] bad;
    bad = 32'h0;
    repeat (2) @(posedge clk_i);
    repeat (32) begin
      @(negedge clk_i);
      bad += {31'h0, pwm !== v};
    end
    chk("pin samples off level", 32'h0, bad);
    @(posedge clk_i);
  endtask
  task irqchk(input logic e);
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    chk("interrupt", {31'h0, e}, {31'h0, irq});
    @(posedge clk_i);
  endtask
  initial begin
    repeat (100000) @(posedge clk_i);
    fail;
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    @(negedge clk_i);
    chk("pins after reset", 32'h0, {29'h0, pwm, oe, irq});
    @(posedge clk_i);
    rd(ctrl_off, ctrl_rst);
    rd(period_off, period_rst);
    rd(pin_dir_off, 8'h01);
    bus(1'h1, priorities_off, 8'ha5);
    rd(priorities_off, 8'ha5 & flag_mask_used);
    bus(1'h1, 8'h28, 8'hff);
    rd(8'h28, 8'h00);
    bus(1'h1, period_off, 8'h03);
    bus(1'h1, duty_sw_off, 8'h02);
    bus(1'h1, ctrl_off, 8'h10);
    bus(1'h1, pin_dir_off, 8'h00);
    for (int i = 0; i < 3; i++) begin
      bus(1'h1, timer_ctrl_off, 8'h04 | 8'(i));
      bus(1'h1, ctrl_off, 8'h1c);
      wrise(3);
      chk("high time", 32'(9 << (2 * i)), {16'h0, hi});
      chk("period", 32'(16 << (2 * i)), {16'h0, per});
    end
    rd(duty_active_off, 8'h02);
    bus(1'h1, duty_sw_off, 8'h01);
    rd(duty_active_off, 8'h02);
    wrise(1);
    chk("high time", 32'h90, {16'h0, hi});
    rd(duty_active_off, 8'h01);
    bus(1'h1, duty_active_off, 8'h55);
    rd(duty_active_off, 8'h01);
    wrise(2);
    chk("high time", 32'h50, {16'h0, hi});
    bus(1'h1, timer_ctrl_off, 8'h04);
    bus(1'h1, duty_sw_off, 8'h3f);
    repeat (40) @(posedge clk_i);
    hold(1'h1);
    bus(1'h1, ctrl_off, ctrl_rst);
    hold(1'h0);
    bus(1'h1, duty_active_off, 8'h55);
    rd(duty_active_off, 8'h55);
    bus(1'h1, duty_sw_off, 8'h00);
    bus(1'h1, ctrl_off, 8'h0c);
    repeat (40) @(posedge clk_i);
    hold(1'h0);
    bus(1'h1, enables_off, 8'h01);
    irqchk(1'h1);
    bus(1'h1, timer_ctrl_off, 8'h00);
    bus(1'h1, enables_off, 8'h00);
    irqchk(1'h0);
    rd(flags_off, flag_mask_used);
    bus(1'h1, enables_off, 8'h01);
    irqchk(1'h1);
    bus(1'h1, flags_off, flag_mask_used);
    irqchk(1'h0);
    rd(flags_off, 8'h00);
    bus(1'h1, timer_count_off, 8'h02);
    rd(timer_count_off, 8'h02);
    report_and_stop;
  end
endmodule
`default_nettype wire

// [src/pwm_pkg.sv]
package pwm_pkg;

  // ****************************************************************
  // Register map (byte addresses, one word each)
  // ****************************************************************
  localparam logic [7:0] ctrl_off        = 8'h00;
  localparam logic [7:0] duty_sw_off     = 8'h04;
  localparam logic [7:0] duty_active_off = 8'h08;
  localparam logic [7:0] timer_ctrl_off  = 8'h0c;
  localparam logic [7:0] timer_count_off = 8'h10;
  localparam logic [7:0] period_off      = 8'h14;
  localparam logic [7:0] flags_off       = 8'h18;
  localparam logic [7:0] enables_off     = 8'h1c;
  localparam logic [7:0] priorities_off  = 8'h20;
  localparam logic [7:0] pin_dir_off     = 8'h24;

  // ****************************************************************
  // Field positions and values
  // ****************************************************************
  localparam int         duty_lo_lsb    = 4;
  localparam int         on_bit         = 2;
  localparam int         post_lsb       = 3;
  localparam logic [1:0] mode_pwm_hi    = 2'h3;
  localparam logic [1:0] presc_div1     = 2'h0;
  localparam logic [1:0] presc_div4     = 2'h1;
  localparam int         flag_period    = 0;
  localparam int         flag_post      = 1;
  localparam logic [7:0] ctrl_rst       = 8'h00;
  localparam logic [7:0] period_rst     = 8'hff;
  localparam logic [7:0] byte_rst       = 8'h00;
  localparam logic [7:0] flag_mask_used = 8'h03;
  localparam logic [5:0] phase_last     = 6'h3f;

  // Counter bits that a timer advance carries
  typedef struct packed {
    logic [7:0] count;
    logic [5:0] phase;
  } timebase_t;

  // AHB address phase captured for the data phase
  typedef struct packed {
    logic       write;
    logic [7:0] addr;
  } ahb_cmd_t;

endpackage

// [src/ten_bit_pwm_channel.sv]
// Our own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// R1 - Drive PWM pin, up to ten bits
// R2 - Zero control word forces channel latch low
// R3 - Period set by period match register
// R4 - Timer equal match clears timer next tick
// R5 - Pin set at restart unless duty zero
// R6 - Restart copies software duty to active latch
// R7 - Postscaler never affects waveform period
// R8 - Duty is register high, control 5:4 low
// R9 - High time is duty times osc times prescale
// R10 - Duty writes anytime, applied at next match
// R11 - Active duty latch is read only; here its byte takes bus writes while the mode is not PWM
// R12 - Active byte plus two-bit latch double-buffer
// R13 - Pin cleared when duty equals time base
// R14 - Duty beyond period keeps pin high
// R15 - Prescaler divides by 1, 4 or 16
// R16 - Software sets period, duty, direction, timer, mode
// R17 - Timer advances every four oscillator phases
module ten_bit_pwm_channel
  import pwm_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Channel pin and interrupt
  output logic             pwm_o,
  output logic             pwm_oe_o,
  output logic             irq_o
);
  import pwm_pkg::*;

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  ahb_cmd_t   cmd_reg;
  logic       wr_pend_reg;
  logic       wr_now;
  logic [7:0] wbyte;

  logic [7:0] ctrl_reg;
  logic [7:0] duty_sw_reg;
  logic [7:0] duty_active_reg;
  logic [1:0] duty_lo_latch_reg;
  logic [7:0] timer_ctrl_reg;
  logic [7:0] period_reg;
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [7:0] enables_reg;
  logic [7:0] priorities_reg;
  logic       pin_dir_reg;
  timebase_t  tb_reg;
  timebase_t  tb_next;
  logic [3:0] post_cnt_reg;
  logic       pin_reg;
  logic       pwm_oe_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_reg     <= '0;
      wr_pend_reg <= 1'b0;
    end else if (hready_i) begin
      cmd_reg.write <= hwrite_i;
      cmd_reg.addr  <= haddr_i[7:0];
      wr_pend_reg   <= hsel_i && htrans_i[1] && hwrite_i;
    end else begin
      wr_pend_reg <= wr_pend_reg;
    end
  end

  // Zero-wait slave: every transfer completes in its first data cycle
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign wr_now      = wr_pend_reg && cmd_reg.write;
  assign wbyte       = hwdata_i[7:0];

  function automatic logic wr_hit(input logic [7:0] off);
    return wr_now && (cmd_reg.addr == off);
  endfunction

  // ****************************************************************
  // Control and configuration registers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= ctrl_rst;
    end else if (wr_hit(ctrl_off)) begin
      ctrl_reg <= {2'h0, wbyte[5:0]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      duty_sw_reg <= byte_rst;
    end else if (wr_hit(duty_sw_off)) begin
      duty_sw_reg <= wbyte; // R10
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_ctrl_reg <= byte_rst;
    end else if (wr_hit(timer_ctrl_off)) begin
      timer_ctrl_reg <= {1'b0, wbyte[6:0]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period_reg <= period_rst;
    end else if (wr_hit(period_off)) begin
      period_reg <= wbyte; // R3
    end
  end

  // Only the two implemented event bits are kept
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enables_reg <= byte_rst;
    end else if (wr_hit(enables_off)) begin
      enables_reg <= wbyte & flag_mask_used;
    end
  end

  // Priorities are storage only; nothing inside reads them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      priorities_reg <= byte_rst;
    end else if (wr_hit(priorities_off)) begin
      priorities_reg <= wbyte & flag_mask_used;
    end
  end

  // Direction resets to input, so the pin floats until software asks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_dir_reg <= 1'b1;
    end else if (wr_hit(pin_dir_off)) begin
      pin_dir_reg <= wbyte[0];
    end
  end

  // ****************************************************************
  // Time base: prescaled phase counter plus 8-bit period timer
  // ****************************************************************
  logic       timer_on;
  logic       pwm_mode;
  logic [1:0] presc_sel;
  logic [3:0] post_top;
  logic [5:0] phase_top;
  logic       tick;
  logic       match;
  logic       restart;
  logic [9:0] duty_sw;
  logic [9:0] duty_act;
  logic [9:0] timebase;

  assign timer_on  = timer_ctrl_reg[on_bit];
  assign pwm_mode  = ctrl_reg[3:2] == mode_pwm_hi;
  assign presc_sel = timer_ctrl_reg[1:0];
  assign post_top  = timer_ctrl_reg[post_lsb+3:post_lsb];

  // ****************************************************************
  // Prescaler decode
  // ****************************************************************
  // Oscillator phases per timer step, less one: 4, 16 or 64 periods
  function automatic logic [5:0] phase_top_of(input logic [1:0] sel);
    logic [5:0] top;
    unique case (sel)
      presc_div1: top = 6'h03; // R15 R17
      presc_div4: top = 6'h0f; // R15
      default:    top = phase_last; // R15
    endcase
    return top;
  endfunction

  // Two low time-base bits: the phase within an unscaled step, or the
  // top two prescaler bits when the step is divided further
  function automatic logic [1:0] tb_low_of(input logic [1:0] sel,
                                           input logic [5:0] ph);
    logic [1:0] low;
    unique case (sel)
      presc_div1: low = ph[1:0];
      presc_div4: low = ph[3:2];
      default:    low = ph[5:4];
    endcase
    return low;
  endfunction

  // True on the first phase of each sub-position; a prescaled compare
  // is then made once per sub-position and not on every phase of it
  function automatic logic sub_start_of(input logic [1:0] sel,
                                        input logic [5:0] ph);
    logic first;
    unique case (sel)
      presc_div1: first = 1'b1;
      presc_div4: first = ph[1:0] == 2'h0;
      default:    first = ph[3:0] == 4'h0;
    endcase
    return first;
  endfunction

  // ****************************************************************
  // Period timer
  // ****************************************************************
  assign phase_top = phase_top_of(presc_sel);
  assign tick      = timer_on && (tb_reg.phase >= phase_top);
  assign match     = tb_reg.count == period_reg;
  assign restart   = tick && match; // R4

  // Next time base, kept apart so the pin compare can look ahead
  always_comb begin
    tb_next = tb_reg;
    if (wr_hit(timer_count_off)) begin
      tb_next.count = wbyte;
      tb_next.phase = 6'h00;
    end else if (tick) begin
      tb_next.phase = 6'h00;
      tb_next.count = match ? 8'h00 : tb_reg.count + 8'h01; // R4
    end else if (timer_on) begin
      tb_next.phase = tb_reg.phase + 6'h01; // R17
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tb_reg <= '0;
    end else begin
      tb_reg <= tb_next;
    end
  end

  // Postscaler only raises its own event; the period ignores it
  always_ff @(posedge clk_i) begin
    if (rst_i || !timer_on) begin
      post_cnt_reg <= 4'h0;
    end else if (restart) begin
      post_cnt_reg <= (post_cnt_reg == post_top)
                      ? 4'h0 : post_cnt_reg + 4'h1; // R7
    end
  end

  // Ten-bit time base as it stands after this edge: comparing the value
  // the registered pin will meet makes the high time exactly duty steps
  assign timebase = {tb_next.count,
                     tb_low_of(presc_sel, tb_next.phase)}; // R13

  assign duty_sw  = {duty_sw_reg,
                     ctrl_reg[duty_lo_lsb+1:duty_lo_lsb]}; // R8
  assign duty_act = {duty_active_reg, duty_lo_latch_reg}; // R12

  // ****************************************************************
  // Double buffer and output latch
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      duty_active_reg   <= byte_rst;
      duty_lo_latch_reg <= 2'h0;
    end else if (restart && pwm_mode) begin
      duty_active_reg   <= duty_sw[9:2]; // R6 R12
      duty_lo_latch_reg <= duty_sw[1:0]; // R6 R12
    end else if (!pwm_mode && wr_hit(duty_active_off)) begin
      duty_active_reg <= wbyte; // R11
    end
  end

  logic sub_ok;
  assign sub_ok = sub_start_of(presc_sel, tb_next.phase);

  always_ff @(posedge clk_i) begin
    if (rst_i || ctrl_reg == ctrl_rst) begin
      pin_reg <= 1'b0; // R2
    end else if (!pwm_mode) begin
      pin_reg <= 1'b0;
    end else if (restart) begin
      // A new period opens high unless the new duty is zero
      pin_reg <= duty_sw != 10'h000; // R5 R6
    end else if (timer_on && sub_ok && duty_act == timebase) begin
      // A duty beyond the period never meets the time base
      pin_reg <= 1'b0; // R13 R14 R9
    end
  end

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  // A data output, so the enable comes from a flip-flop like the level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_oe_reg <= 1'b0;
    end else begin
      pwm_oe_reg <= !pin_dir_reg;
    end
  end

  assign pwm_o    = pin_reg; // R1
  assign pwm_oe_o = pwm_oe_reg;

  // ****************************************************************
  // Event flags and interrupt
  // ****************************************************************
  logic post_evt;
  assign post_evt = restart && timer_on
                    && (post_cnt_reg == post_top);

  always_comb begin
    flags_next = flags_reg;
    if (wr_hit(flags_off)) begin
      flags_next = flags_reg & ~wbyte;
    end
    // Set beats a same-cycle clear
    if (restart) begin
      flags_next[flag_period] = 1'b1;
    end
    if (post_evt) begin
      flags_next[flag_post] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_reg <= byte_rst;
    end else begin
      flags_reg <= flags_next & flag_mask_used;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      // From the next flags, so the line rises with the flag itself
      irq_o <= |(flags_next & enables_reg);
    end
  end

  // ****************************************************************
  // Read mux
  // ****************************************************************
  // Decoded in the address phase, so data stand through the data phase
  logic [7:0] rd_byte;
  always_comb begin
    unique case (haddr_i[7:0])
      ctrl_off:        rd_byte = ctrl_reg;
      duty_sw_off:     rd_byte = duty_sw_reg;
      duty_active_off: rd_byte = duty_active_reg;
      timer_ctrl_off:  rd_byte = timer_ctrl_reg;
      timer_count_off: rd_byte = tb_reg.count;
      period_off:      rd_byte = period_reg;
      flags_off:       rd_byte = flags_reg;
      enables_off:     rd_byte = enables_reg;
      priorities_off:  rd_byte = priorities_reg;
      pin_dir_off:     rd_byte = {7'h00, pin_dir_reg};
      default:         rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i) begin
      hrdata_o <= {24'h000000, rd_byte};
    end
  end

endmodule
`default_nettype wire
